//--- lpm_top.sv
// Overview of operation
// RULE1 - The loop runs short time constant while fast-lock select is active or no video is recognised, else long; CTRL_FORCE_SHORT also selects short.
// RULE2 - The outside party requests fast-lock mode by pulling the select pin low (below 2.1 V); high means normal.
// RULE3 - The time constant is switched only through the comparator current amplitude, never filter parts.
// RULE4 - Comparator gain is 0.16 mA/rad in long mode and 0.47 mA/rad in short mode.
// RULE5 - Comparator current is about 500 uA in long mode and about 1.5 mA in short mode.
// RULE6 - Once per line the stage checks whether line sync coincides with a 2 us sampling pulse.
// RULE7 - The 2 us sampling pulse sits at the centre of line sync when the loop is locked.
// RULE8 - Video present or absent is reported, and absence raises the no-video flag forcing short mode.
// RULE9 - The accumulated recognition result drives an output for sound mute and tuning inhibit.
// RULE10 - The recognition decision uses a threshold with hysteresis so it does not toggle at the margin.
// RULE11 - The comparator is inhibited during the frame-retrace inhibit interval.
// RULE12 - The comparator is also inhibited during the extracted frame sync pulse.
// RULE13 - In long mode the comparator is also inhibited during line trace outside blanking, qualified by video ident.
// RULE14 - Line-trace inhibition is not applied from frame line 8 to line 21.
// RULE15 - In short mode only frame-retrace and frame-sync terms inhibit, qualified by video ident.
// RULE16 - Recognition is an up/down counter stepped once per line, with thresholds giving about 1 ms.
`timescale 1ns/100ps
module lpm_top (
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  input  wire logic        i_fast_lock_select_n,
  input  wire logic        i_line_sync,
  input  wire logic        i_line_start,
  input  wire logic        i_frame_start,
  input  wire logic        i_frame_retrace_inhibit,
  input  wire logic        i_extracted_frame_sync,
  input  wire logic        i_blanking_window,
  input  wire logic        i_line_trace_window,
  output logic             o_short_mode,
  output logic [10:0]      o_comp_current_ua,
  output logic [8:0]       o_comp_gain_urad,
  output logic             o_comp_inhibit,
  output logic             o_sample_pulse,
  output logic             o_video_present,
  output logic             o_no_video,
  output logic             o_irq
);
  import lpm_pkg::*;

  typedef struct packed {
    logic        fl_meta;
    logic        fl_s;
    logic        sync_meta;
    logic        sync_s;
    logic [11:0] phase;
    logic        hit;
    logic [4:0]  acc;
    logic        vp;
    logic        no_video;
    logic [8:0]  frame_line;
    logic [1:0]  ctrl;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        irq;
    logic        short_m;
    logic [10:0] cur;
    logic [8:0]  gain;
    logic        inhibit;
    logic        samp;
  } lpm_state_t;

  lpm_state_t st;
  lpm_state_t next_st;

  logic       samp_win;
  logic       frame_free;
  logic       setup;
  logic       wr_acc;
  logic [1:0] ev;
  logic       inh_long;
  logic       inh_short;
  logic       want_short;

  always_comb begin
    next_st = st;
    ev = 2'h0;
    // Two-flop synchronisers for the fast-lock select and line sync pins
    next_st.fl_meta   = i_fast_lock_select_n;
    next_st.fl_s      = st.fl_meta;
    next_st.sync_meta = i_line_sync;
    next_st.sync_s    = st.sync_meta;

    // Line phase from the divided oscillator; 2 us window centred on sync
    samp_win = (st.phase >= SAMP_BEGIN) && (st.phase < SAMP_END); // RULE7
    next_st.samp = samp_win;
    if (i_line_start) begin
      next_st.phase = 12'h000;
      next_st.hit   = 1'b0;
      // Saturating up/down step, once per line
      if (st.hit && st.acc != ACC_MAX) begin // RULE16
        next_st.acc = st.acc + 5'h01;
      end else if (!st.hit && st.acc != 5'h00) begin
        next_st.acc = st.acc - 5'h01;
      end
    end else begin
      if (st.phase != 12'hfff) begin
        next_st.phase = st.phase + 12'h001;
      end
      if (samp_win && st.sync_s) begin // RULE6
        next_st.hit = 1'b1;
      end
    end

    // Hysteresis on the accumulated value
    if (st.acc >= ACC_TH_HI) begin // RULE10
      next_st.vp = 1'b1;
    end else if (st.acc <= ACC_TH_LO) begin
      next_st.vp = 1'b0;
    end
    // Mute output kept in its own flop so the pin never sees a gate
    next_st.no_video = !next_st.vp; // RULE9
    ev[EV_VIDEO_FOUND] = next_st.vp && !st.vp; // RULE8
    ev[EV_VIDEO_LOST]  = !next_st.vp && st.vp;

    // Frame line count, saturating so long frames never wrap into the free range
    if (i_frame_start) begin
      // Frame start precedes the first line start, which brings the count to 1
      next_st.frame_line = i_line_start ? 9'h001 : 9'h000;
    end else if (i_line_start && st.frame_line != 9'h1ff) begin
      next_st.frame_line = st.frame_line + 9'h001;
    end
    frame_free = (st.frame_line >= FRAME_FREE_FIRST) && (st.frame_line <= FRAME_FREE_LAST);

    // Select pin is active low
    want_short = !st.fl_s || !st.vp || st.ctrl[CTRL_FORCE_SHORT]; // RULE1 RULE2 RULE8
    next_st.short_m = want_short;
    // Only the comparator current and gain move; the loop filter is left alone
    next_st.cur  = want_short ? CUR_SHORT_UA : CUR_LONG_UA; // RULE3 RULE5
    next_st.gain = want_short ? GAIN_SHORT_URAD : GAIN_LONG_URAD; // RULE4

    // Mode term is the registered one, three cycles behind the select pin
    inh_short = st.vp && (i_frame_retrace_inhibit || i_extracted_frame_sync); // RULE11 RULE12 RULE15
    inh_long  = st.vp && (i_frame_retrace_inhibit || i_extracted_frame_sync
                || (!i_blanking_window && i_line_trace_window && !frame_free)); // RULE13 RULE14
    next_st.inhibit = st.ctrl[CTRL_INH_EN] && (st.short_m ? inh_short : inh_long); // RULE15

    // APB slave: data prepared in setup, one access cycle with pready high
    setup  = i_psel && !i_penable && !st.pready;
    wr_acc = i_psel && i_penable && st.pready && i_pwrite;
    next_st.pready  = setup;
    next_st.pslverr = 1'b0;
    if (setup) begin
      next_st.prdata = 32'h0;
      case (i_paddr)
        ADDR_CTRL:   next_st.prdata[1:0] = st.ctrl;
        ADDR_STATUS: next_st.prdata[1:0] = st.status;
        ADDR_MASK:   next_st.prdata[1:0] = st.mask;
        ADDR_STATE: begin
          next_st.prdata[ST_VIDEO] = st.vp;
          next_st.prdata[ST_SHORT] = st.short_m;
          next_st.prdata[ST_INH]   = st.inhibit;
          next_st.prdata[ST_ACC_LSB +: 5]  = st.acc;
          next_st.prdata[ST_LINE_LSB +: 9] = st.frame_line;
        end
        default: next_st.pslverr = 1'b1;
      endcase
    end else begin
      // Read data stands only with pready, zero otherwise
      next_st.prdata = 32'h0;
    end
    // Set wins over the write-one clear
    next_st.status = st.status | ev;
    if (wr_acc) begin
      case (i_paddr)
        ADDR_CTRL:   next_st.ctrl = i_pwdata[1:0];
        ADDR_STATUS: next_st.status = (st.status & ~i_pwdata[1:0]) | ev;
        ADDR_MASK:   next_st.mask = i_pwdata[1:0];
        default: ;
      endcase
    end
    next_st.irq = |(next_st.status & next_st.mask);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      // Pins start idle; mode stays short until video is found
      st      <= '0;
      st.fl_meta <= 1'b1;
      st.fl_s    <= 1'b1;
      st.no_video <= 1'b1;
      st.ctrl    <= CTRL_RESET;
      st.short_m <= 1'b1;
      st.cur     <= CUR_SHORT_UA;
      st.gain    <= GAIN_SHORT_URAD;
    end else begin
      st <= next_st;
    end
  end

  assign o_pready          = st.pready;
  assign o_prdata          = st.prdata;
  assign o_pslverr         = st.pslverr;
  assign o_short_mode      = st.short_m;
  assign o_comp_current_ua = st.cur;
  assign o_comp_gain_urad  = st.gain;
  assign o_comp_inhibit    = st.inhibit;
  assign o_sample_pulse    = st.samp;
  assign o_video_present   = st.vp;
  assign o_no_video        = st.no_video;
  assign o_irq             = st.irq;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  a_fast_lock_short: assert property (!st.fl_s |=> o_short_mode) // RULE1
    else $error("fast lock select did not force short mode");
  a_novideo_short: assert property (!st.vp |=> o_short_mode) // RULE8
    else $error("no video did not force short mode");
  a_force_short: assert property (st.ctrl[CTRL_FORCE_SHORT] |=> o_short_mode) // RULE1
    else $error("force bit did not select short mode");
  a_long_when_idle: assert property (st.fl_s && st.vp && !st.ctrl[CTRL_FORCE_SHORT] |=> !o_short_mode) // RULE1
    else $error("long mode not selected");
  a_current_mode: assert property (o_comp_current_ua == (o_short_mode ? CUR_SHORT_UA : CUR_LONG_UA)) // RULE5
    else $error("comparator current does not match mode");
  a_gain_mode: assert property (o_comp_gain_urad == (o_short_mode ? GAIN_SHORT_URAD : GAIN_LONG_URAD)) // RULE4
    else $error("comparator gain does not match mode");
  a_sample_hit: assert property (st.sync_s && samp_win && !i_line_start |=> st.hit) // RULE6
    else $error("coincidence missed");
  a_no_hit_outside: assert property (!st.hit && !samp_win |=> !st.hit) // RULE7
    else $error("coincidence taken outside sampling pulse");
  a_acc_step_up: assert property (i_line_start && st.hit && st.acc < ACC_MAX |=> st.acc == $past(st.acc) + 5'h01) // RULE16
    else $error("accumulator failed to step up");
  a_hyst_rise: assert property ($rose(st.vp) |-> $past(st.acc) >= ACC_TH_HI) // RULE10
    else $error("video recognised below upper threshold");
  a_hyst_fall: assert property ($fell(st.vp) |-> $past(st.acc) <= ACC_TH_LO) // RULE10
    else $error("video dropped above lower threshold");
  a_mute_out: assert property (o_no_video == !o_video_present) // RULE9
    else $error("mute output disagrees with recognition");
  a_retrace_inh: assert property (i_frame_retrace_inhibit && st.vp && st.ctrl[CTRL_INH_EN] |=> o_comp_inhibit) // RULE11
    else $error("no inhibit during frame retrace");
  a_fsync_inh: assert property (i_extracted_frame_sync && st.vp && st.ctrl[CTRL_INH_EN] |=> o_comp_inhibit) // RULE12
    else $error("no inhibit during frame sync");
  a_trace_inh: assert property (!st.short_m && st.vp && st.ctrl[CTRL_INH_EN] && i_line_trace_window
                                && !i_blanking_window && !frame_free |=> o_comp_inhibit) // RULE13
    else $error("no inhibit during line trace in long mode");
  a_frame_free: assert property (frame_free && !i_frame_retrace_inhibit && !i_extracted_frame_sync
                                 |=> !o_comp_inhibit) // RULE14
    else $error("line trace inhibited in lines 8 to 21");
  a_short_no_trace: assert property (st.short_m && !i_frame_retrace_inhibit && !i_extracted_frame_sync
                                     |=> !o_comp_inhibit) // RULE15
    else $error("line trace inhibited in short mode");

  // Accumulator moves only at line starts and never leaves its range
  a_acc_step_down: assert property (i_line_start && !st.hit && st.acc != 5'h00 // RULE16
                                    |=> st.acc == $past(st.acc) - 5'h01)
    else $error("accumulator failed to step down");
  a_acc_hold: assert property (!i_line_start |=> st.acc == $past(st.acc)) // RULE16
    else $error("accumulator moved inside a line");
  a_acc_bound: assert property (st.acc <= ACC_MAX) // RULE16
    else $error("accumulator above its ceiling");
  a_hit_clear: assert property (i_line_start |=> !st.hit) // RULE6
    else $error("coincidence carried into the next line");

  // Between the thresholds the decision must hold still
  a_hyst_hold: assert property (st.acc > ACC_TH_LO && st.acc < ACC_TH_HI |=> $stable(st.vp)) // RULE10
    else $error("recognition toggled between thresholds");
  a_mute_rise: assert property ($rose(o_no_video) |-> $past(st.acc) <= ACC_TH_LO) // RULE9
    else $error("mute raised above lower threshold");
  a_found_event: assert property ($rose(st.vp) |-> st.status[EV_VIDEO_FOUND]) // RULE8
    else $error("video found event not latched");
  a_lost_event: assert property ($fell(st.vp) |-> st.status[EV_VIDEO_LOST]) // RULE8
    else $error("video lost event not latched");

  // Sampling pulse opens exactly at its programmed phase
  a_sample_start: assert property ($rose(o_sample_pulse) |-> $past(st.phase) == SAMP_BEGIN) // RULE7
    else $error("sampling pulse opened at the wrong phase");

  // Mode change moves current and gain in the same cycle
  a_current_switch: assert property ($changed(o_short_mode) |-> $changed(o_comp_current_ua)) // RULE3
    else $error("current did not follow a mode change");
  a_gain_switch: assert property ($changed(o_short_mode) |-> $changed(o_comp_gain_urad)) // RULE4
    else $error("gain did not follow a mode change");

  // Frame line count that places the free range
  a_line_count: assert property (i_line_start && !i_frame_start && st.frame_line != 9'h1ff // RULE14
                                 |=> st.frame_line == $past(st.frame_line) + 9'h001)
    else $error("frame line count did not advance");
  a_frame_restart: assert property (i_frame_start && !i_line_start |=> st.frame_line == 9'h000) // RULE14
    else $error("frame line count not restarted");

  // Inhibit needs video, the enable bit and a cause
  a_no_inh_disabled: assert property (!st.ctrl[CTRL_INH_EN] |=> !o_comp_inhibit) // RULE11
    else $error("inhibit raised while disabled");
  a_no_inh_novideo: assert property (!st.vp |=> !o_comp_inhibit) // RULE13
    else $error("inhibit raised without video");
  a_blank_no_trace: assert property (!st.short_m && i_blanking_window && !i_frame_retrace_inhibit // RULE13
                                     && !i_extracted_frame_sync |=> !o_comp_inhibit)
    else $error("line trace inhibited during blanking");
  a_inh_cause: assert property (o_comp_inhibit && !$past(i_frame_retrace_inhibit) // RULE13
                                && !$past(i_extracted_frame_sync) |-> $past(i_line_trace_window))
    else $error("inhibit raised without a cause");
endmodule

//--- lpm_pkg.sv
package lpm_pkg;
  // Timing, all from the 40 MHz core clock
  localparam int CLK_MHZ          = 40;
  localparam int SAMPLE_NS        = 2000;
  localparam int SYNC_WIDTH_NS    = 4700;
  localparam int SAMPLE_CYC       = SAMPLE_NS * CLK_MHZ / 1000;
  localparam int SAMPLE_BEGIN_CYC = ((SYNC_WIDTH_NS - SAMPLE_NS) / 2) * CLK_MHZ / 1000;
  localparam logic [11:0] SAMP_BEGIN = 12'(SAMPLE_BEGIN_CYC);
  localparam logic [11:0] SAMP_END   = 12'(SAMPLE_BEGIN_CYC + SAMPLE_CYC);

  // Recognition accumulator, one step per line (about 16 lines = 1 ms)
  localparam logic [4:0] ACC_MAX = 5'h14;
  localparam logic [4:0] ACC_TH_HI = 5'h10;
  localparam logic [4:0] ACC_TH_LO = 5'h04;

  // Frame lines where line-trace inhibition is lifted
  localparam logic [8:0] FRAME_FREE_FIRST = 9'h008;
  localparam logic [8:0] FRAME_FREE_LAST  = 9'h015;

  // Comparator current (uA) and conversion gain (uA per rad)
  localparam logic [10:0] CUR_LONG_UA    = 11'h1f4;
  localparam logic [10:0] CUR_SHORT_UA   = 11'h5dc;
  localparam logic [8:0]  GAIN_LONG_URAD  = 9'h0a0;
  localparam logic [8:0]  GAIN_SHORT_URAD = 9'h1d6;

  // Register map
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK   = 8'h08;
  localparam logic [7:0] ADDR_STATE  = 8'h0c;
  localparam int CTRL_FORCE_SHORT = 0;
  localparam int CTRL_INH_EN      = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  localparam int EV_VIDEO_FOUND = 0;
  localparam int EV_VIDEO_LOST  = 1;
  localparam int ST_VIDEO   = 0;
  localparam int ST_SHORT   = 1;
  localparam int ST_INH     = 2;
  localparam int ST_ACC_LSB = 8;
  localparam int ST_LINE_LSB = 16;
endpackage

//--- lpm_sync_model.sv
`timescale 1ns/100ps
module lpm_sync_model #(
  parameter int LINE_CYC    = 200,
  parameter int FRAME_LINES = 30
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_video_on,
  output logic            o_line_start,
  output logic            o_frame_start,
  output logic            o_line_sync,
  output logic [8:0]      o_line_no
);
  int phase = 0;
  initial {o_line_start, o_frame_start, o_line_sync, o_line_no} = '0;
  always @(posedge i_clk) begin
    phase <= (i_rst || phase == LINE_CYC - 1) ? 0 : phase + 1;
    o_line_start <= !i_rst && phase == LINE_CYC - 1;
    o_frame_start <= !i_rst && phase == LINE_CYC - 2 && o_line_no == 9'(FRAME_LINES);
    // Sync low when no video, so nothing stale can coincide
    o_line_sync <= !i_rst && i_video_on && phase < 187;
    if (i_rst)
      o_line_no <= 9'h000;
    else if (o_line_start)
      o_line_no <= (o_line_no == 9'(FRAME_LINES)) ? 9'h001 : o_line_no + 9'h001;
  end
endmodule

//--- line_pll_mode_and_inhibit_control_bench.sv
`timescale 1ns/100ps
module line_pll_mode_and_inhibit_control_bench;
  import lpm_pkg::*;
  logic        i_core_clk = 0, i_sys_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, rd, o_prdata;
  logic        i_fast_lock_select_n = 1, i_frame_retrace_inhibit = 0, i_extracted_frame_sync = 0;
  logic        i_blanking_window = 0, i_line_trace_window = 0, video_on = 0, er;
  logic        i_line_sync, i_line_start, i_frame_start, o_pready, o_pslverr, o_short_mode;
  logic        o_comp_inhibit, o_sample_pulse, o_video_present, o_no_video, o_irq;
  logic [10:0] o_comp_current_ua;
  logic [8:0]  o_comp_gain_urad, line_no;
  int          err_total = 0, samples_checked = 0, cyc = 0;
  // {fast_n, fri, fs, blk, trace, in_free_lines, inhibit}
  logic [6:0]  rows [9] = '{7'b1000000, 7'b1100001, 7'b1010001, 7'b1000101, 7'b1001100,
                            7'b1000110, 7'b1100111, 7'b0000100, 7'b0010001};

  lpm_top u_dut (.i_core_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_pready, .o_prdata, .o_pslverr, .i_fast_lock_select_n, .i_line_sync, .i_line_start,
    .i_frame_start, .i_frame_retrace_inhibit, .i_extracted_frame_sync, .i_blanking_window,
    .i_line_trace_window, .o_short_mode, .o_comp_current_ua, .o_comp_gain_urad, .o_comp_inhibit,
    .o_sample_pulse, .o_video_present, .o_no_video, .o_irq);
  lpm_sync_model u_far (.i_clk(i_core_clk), .i_rst(i_sys_rst), .i_video_on(video_on),
    .o_line_start(i_line_start), .o_frame_start(i_frame_start), .o_line_sync(i_line_sync),
    .o_line_no(line_no));

  always #12.5 i_core_clk = ~i_core_clk;

  task automatic print_verdict();
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Hang guard, well above the longest frame wait
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    // One idle edge so a following call never re-raises psel in its release step
    @(posedge i_core_clk);
    i_psel <= 1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1;
    do @(posedge i_core_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
  endtask

  // Acc and flag land a few edges after the line boundary
  task automatic lines(input int n);
    repeat (n) @(posedge i_line_start);
    repeat (4) @(posedge i_core_clk);
  endtask

  initial begin
    repeat (3) @(posedge i_core_clk);
    i_sys_rst <= 0;
    chk({o_short_mode, o_video_present, o_no_video, o_irq, o_comp_inhibit}, 5'b10100);
    chk({o_pready, o_pslverr, o_sample_pulse}, 3'h0);
    chk(o_comp_current_ua, CUR_SHORT_UA);
    chk(o_comp_gain_urad, GAIN_SHORT_URAD);
    apb(0, ADDR_CTRL, 0);
    chk(rd, CTRL_RESET);
    apb(0, 8'h10, 32'hffff_ffff);
    chk({er, rd}, 33'h1_0000_0000);
    apb(1, ADDR_MASK, 32'h3);
    video_on <= 1;
    lines(12);
    chk(o_video_present, 0);
    lines(8);
    chk({o_video_present, o_no_video, o_short_mode, o_irq}, 4'b1001);
    chk(o_comp_current_ua, CUR_LONG_UA);
    apb(0, ADDR_STATUS, 0);
    chk(rd, 32'h1);
    apb(1, ADDR_STATUS, 32'h1);
    repeat (2) @(posedge i_core_clk);
    chk(o_irq, 0);
    @(posedge i_line_start);
    repeat (30) @(posedge i_core_clk);
    chk(o_sample_pulse, 0);
    repeat (64) @(posedge i_core_clk);
    chk(o_sample_pulse, 1);
    repeat (76) @(posedge i_core_clk);
    chk(o_sample_pulse, 0);
    foreach (rows[k]) begin
      while (rows[k][1] ? (line_no < 10 || line_no > 18) : (line_no < 22 || line_no > 28))
        @(posedge i_core_clk);
      {i_fast_lock_select_n, i_frame_retrace_inhibit, i_extracted_frame_sync, i_blanking_window,
       i_line_trace_window} <= rows[k][6:2];
      repeat (7) @(posedge i_core_clk);
      chk(o_comp_inhibit, rows[k][0]);
      chk(o_short_mode, !rows[k][6]);
      chk(o_comp_gain_urad, rows[k][6] ? GAIN_LONG_URAD : GAIN_SHORT_URAD);
    end
    {i_fast_lock_select_n, i_frame_retrace_inhibit, i_extracted_frame_sync} <= 3'b110;
    apb(1, ADDR_CTRL, 32'h1);
    repeat (3) @(posedge i_core_clk);
    chk({o_short_mode, o_comp_inhibit}, 2'b10);
    apb(1, ADDR_CTRL, 32'h2);
    i_frame_retrace_inhibit <= 0;
    video_on <= 0;
    lines(10);
    chk(o_video_present, 1);
    lines(20);
    chk({o_video_present, o_no_video, o_short_mode, o_irq}, 4'b0111);
    apb(1, ADDR_MASK, 32'h0);
    repeat (2) @(posedge i_core_clk);
    chk(o_irq, 0);
    apb(0, ADDR_STATUS, 0);
    chk(rd, 32'h2);
    // Mid-run reset must drop the sticky lost event
    i_sys_rst <= 1;
    repeat (2) @(posedge i_core_clk);
    i_sys_rst <= 0;
    chk({o_short_mode, o_video_present, o_no_video, o_irq, o_comp_inhibit, o_pready}, 6'b101000);
    apb(0, ADDR_STATUS, 0);
    chk(rd, 32'h0);
    print_verdict();
  end
endmodule
